// File: design/usart_pkg.sv
// shared constants and types for the serial port core
package usart_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;

  // register byte offsets
  localparam logic [7:0] OFS_DATA   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CTRL1  = 8'h08;
  localparam logic [7:0] OFS_CTRL2  = 8'h0c;
  localparam logic [7:0] OFS_BAUD   = 8'h10;

  // status bits
  localparam int ST_PAR_ERR = 0;
  localparam int ST_FRM_ERR = 1;
  localparam int ST_OVERRUN = 2;
  localparam int ST_TXC     = 5;
  localparam int ST_RXC     = 6;
  localparam int ST_DRE     = 7;
  localparam int ST_TXIRQ   = 8;
  localparam int ST_RXIRQ   = 9;
  localparam int ST_DREIRQ  = 10;

  // control one bits
  localparam int C1_RX_EN   = 0;
  localparam int C1_TX_EN   = 1;
  localparam int C1_RXC_IE  = 2;
  localparam int C1_TXC_IE  = 3;
  localparam int C1_DRE_IE  = 4;
  localparam int C1_PAR_ODD = 5;
  localparam int C1_PAR_EN  = 6;
  localparam int C1_SIZE_LO = 8;
  localparam int C1_SYNC    = 11;

  // control two bits
  localparam int C2_TX9     = 0;
  localparam int C2_RX9     = 1;
  localparam int C2_STOP2   = 2;
  localparam int C2_DBLS    = 3;

  localparam logic [2:0] SIZE_9BIT  = 3'h7;
  localparam logic [4:0] OVS_NORMAL = 5'h10;
  localparam logic [4:0] OVS_DOUBLE = 5'h08;
  localparam logic [4:0] MID_NORMAL = 5'h08;
  localparam logic [4:0] MID_DOUBLE = 5'h04;
  localparam logic [3:0] DATA_BITS_BASE = 4'h5;
  localparam logic [15:0] BAUD_RESET = 16'h0000;

  typedef struct packed {
    logic       par_err;
    logic       frm_err;
    logic       ovr;
    logic       ninth;
    logic [7:0] data;
  } rx_entry_t;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
endpackage

// File: design/usart_tx_rx_core.sv
// transmit and receive datapath of the serial port with wishbone registers
// Behaviour
// - buffer moves into shifter only when shifter idle or right after last stop
// - buffer-empty flag follows buffer state; writing zero clears, one ignored
// - buffer-empty request while flag and its enable are both set
// - transmit-complete sets after frame out with empty buffer; clears on ack or zero
// - transmit-complete request while flag and its enable are set
// - parity bit inserted after data msb, before first stop bit
// - transmitter disable waits for the current and any pending buffered frame, then frees the pin
// - reception starts on valid low start bit, samples each bit until stop
// - second stop ignored; first stop moves frame to buffer, back to idle
// - ninth received bit stored readable before the low data byte
// - error flags stored in same two-entry fifo slot as their character
// - receive-complete set while unread data; receiver disable flushes and clears
// - receive-complete request while flag and its enable are set
// - frame error is one when first stop sampled low, else zero
// - overrun set when frame completes into full buffer; data lost until read
// - parity error on mismatch when enabled; reads zero when disabled
// - receiver disable stops at once, resets buffered data, frees pin
// - receiver oversamples 16x normally, 8x in double speed
// - after falling edge, samples 8,9,10 (4,5,6 in double speed) majority-low confirm start and resync
// - data and parity bits decided by majority of the three centre samples
// - stop valid with two of three high, else frame error, then idle
// - even parity is xor of data bits, odd parity its inverse
// - bit clock divides by 16, 8 or 2 times divisor plus one
// - frame: low start, 5-9 data lsb first, optional parity, 1-2 high stops
//
// The register offsets and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
module usart_tx_rx_core
  import usart_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        serial_in_pin_i,
  input  wire logic        serial_clock_pin_i,
  output logic             serial_out_pin_o,
  output logic             serial_out_pin_oe_o,
  output logic             serial_in_pin_owned_o,
  input  wire logic        txc_irq_ack_i,
  output logic             dre_irq_o,
  output logic             txc_irq_o,
  output logic             rxc_irq_o
);
  function automatic logic maj3(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  logic [11:0]      ctrl1_ff;
  logic [3:0]       ctrl2_ff;
  logic [DIV_W-1:0] baud_ff;
  logic             ack_ff;
  logic [31:0]      rdat_ff;
  logic             req;
  logic             wr_data, wr_stat, rd_data;

  assign req     = cyc_i & stb_i & ~ack_ff;
  assign wr_data = req & we_i & (adr_i == OFS_DATA) & sel_i[0];
  assign wr_stat = req & we_i & (adr_i == OFS_STATUS) & sel_i[0];
  assign rd_data = req & ~we_i & (adr_i == OFS_DATA);

  logic rx_en, tx_en_cfg, par_en, par_odd, dbls, sync_mode, stop2;
  logic [2:0] csize;
  logic [3:0] nbits;
  assign rx_en     = ctrl1_ff[C1_RX_EN];
  assign tx_en_cfg = ctrl1_ff[C1_TX_EN];
  assign par_en    = ctrl1_ff[C1_PAR_EN];
  assign par_odd   = ctrl1_ff[C1_PAR_ODD];
  assign sync_mode = ctrl1_ff[C1_SYNC];
  assign csize     = ctrl1_ff[C1_SIZE_LO +: 3];
  assign dbls      = ctrl2_ff[C2_DBLS];
  assign stop2     = ctrl2_ff[C2_STOP2];
  // size codes 4..6 are reserved; treat them as eight bits
  assign nbits = (csize == SIZE_9BIT) ? 4'h9 :
                 (csize > 3'h3) ? 4'h8 : DATA_BITS_BASE + {1'b0, csize};

  // control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl1_ff <= '0;
      ctrl2_ff <= '0;
      baud_ff  <= DIV_W'(BAUD_RESET);
    end else if (req & we_i & sel_i[0]) begin
      if (adr_i == OFS_CTRL1) begin
        ctrl1_ff[7:0] <= dat_i[7:0];
      end
      if (adr_i == OFS_CTRL2) begin
        ctrl2_ff[C2_TX9]   <= dat_i[C2_TX9];
        ctrl2_ff[C2_STOP2] <= dat_i[C2_STOP2];
        ctrl2_ff[C2_DBLS]  <= dat_i[C2_DBLS];
      end
      if (adr_i == OFS_BAUD) begin
        baud_ff[7:0] <= dat_i[7:0];
      end
    end else if (req & we_i & sel_i[1]) begin
      if (adr_i == OFS_CTRL1) begin
        ctrl1_ff[11:8] <= dat_i[11:8];
      end
      if (adr_i == OFS_BAUD) begin
        baud_ff[DIV_W-1:8] <= dat_i[DIV_W-1:8];
      end
    end
  end

  // oversample tick: divisor+1 clocks; tx bit uses 16 or 8 ticks, sync master 2 per bit
  logic [DIV_W-1:0] div_ff;
  logic             tick;
  assign tick = (div_ff == baud_ff);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_ff <= '0;
    end else begin
      div_ff <= tick ? '0 : div_ff + 1'b1;
    end
  end
  logic [4:0] ovs, mid;
  assign ovs = sync_mode ? 5'h02 : (dbls ? OVS_DOUBLE : OVS_NORMAL);
  assign mid = dbls ? MID_DOUBLE : MID_NORMAL;

  // ---------------- transmitter ----------------
  tx_state_t  tx_st_ff;
  logic [8:0] tbuf_ff, tsh_ff;
  logic       tbuf_full_ff, dre_ff, txc_ff, tx_en_ff, tpar_ff;
  logic [3:0] tbit_ff;
  logic [4:0] tcnt_ff;
  logic       tstop_ff, tx_out_ff;
  logic       tx_bit_end, tx_load;
  assign tx_bit_end = tick & (tcnt_ff == ovs - 5'h01);
  assign tx_load = tbuf_full_ff & tx_en_ff &
                   ((tx_st_ff == TX_IDLE) | (tx_st_ff == TX_STOP & tx_bit_end & (tstop_ff | ~stop2)));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tbuf_ff      <= '0;
      tbuf_full_ff <= 1'b0;
    end else if (wr_data & (tx_en_cfg | rx_en)) begin
      tbuf_ff      <= {ctrl2_ff[C2_TX9], dat_i[7:0]};
      tbuf_full_ff <= 1'b1;
    end else if (tx_load) begin
      tbuf_full_ff <= 1'b0;
    end
  end

  // empty flag tracks the buffer; zero write clears, a later load or empty sets again
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dre_ff <= 1'b1;
    end else if (wr_data & (tx_en_cfg | rx_en)) begin
      dre_ff <= 1'b0;
    end else if (tx_load) begin
      dre_ff <= 1'b1;
    end else if (wr_stat & ~dat_i[ST_DRE]) begin
      dre_ff <= 1'b0;
    end
  end

  // disable only lands between frames
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_en_ff <= 1'b0;
    end else if (tx_st_ff == TX_IDLE) begin
      tx_en_ff <= tx_en_cfg;
    end
  end

  logic frame_done;
  assign frame_done = (tx_st_ff == TX_STOP) & tx_bit_end & (tstop_ff | ~stop2);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txc_ff <= 1'b0;
    end else if (frame_done & ~tbuf_full_ff) begin
      txc_ff <= 1'b1;  // set wins over clear
    end else if (txc_irq_ack_i | (wr_stat & ~dat_i[ST_TXC])) begin
      txc_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_st_ff  <= TX_IDLE;
      tsh_ff    <= '0;
      tbit_ff   <= '0;
      tcnt_ff   <= '0;
      tstop_ff  <= 1'b0;
      tpar_ff   <= 1'b0;
      tx_out_ff <= 1'b1;
    end else if (tx_load) begin
      tx_st_ff  <= TX_START;
      tsh_ff    <= tbuf_ff;
      tbit_ff   <= '0;
      tcnt_ff   <= '0;
      tstop_ff  <= 1'b0;
      tpar_ff   <= par_odd;
      tx_out_ff <= 1'b0;
    end else if (tick & (tx_st_ff != TX_IDLE)) begin
      tcnt_ff <= tx_bit_end ? 5'h00 : tcnt_ff + 5'h01;
      if (tx_bit_end) begin
        unique case (tx_st_ff)
          TX_START, TX_DATA: begin
            if (tx_st_ff == TX_DATA && tbit_ff == nbits) begin
              tx_st_ff  <= par_en ? TX_PAR : TX_STOP;
              tx_out_ff <= par_en ? tpar_ff : 1'b1;
            end else begin
              tx_st_ff  <= TX_DATA;
              tx_out_ff <= tsh_ff[0];  // lsb first
              tpar_ff   <= tpar_ff ^ tsh_ff[0];
              tsh_ff    <= {1'b0, tsh_ff[8:1]};
              tbit_ff   <= tbit_ff + 4'h1;
            end
          end
          TX_PAR: begin
            tx_st_ff  <= TX_STOP;
            tx_out_ff <= 1'b1;
          end
          TX_STOP: begin
            if (stop2 & ~tstop_ff) begin
              tstop_ff <= 1'b1;
            end else begin
              tx_st_ff <= TX_IDLE;
            end
          end
          TX_IDLE: tx_st_ff <= TX_IDLE;
        endcase
      end
    end
  end
  assign serial_out_pin_o    = tx_out_ff;
  assign serial_out_pin_oe_o = tx_en_ff | (tx_st_ff != TX_IDLE);

  // ---------------- receiver ----------------
  rx_state_t  rx_st_ff;
  logic       rin_ff, sck_ff, rx_stb;
  logic [4:0] rcnt_ff;
  logic [2:0] smp_ff;
  logic [3:0] rbit_ff;
  logic [8:0] rsh_ff;
  logic       rpar_ff, rpe_ff;
  logic       rx_push;
  rx_entry_t  rx_new;
  rx_entry_t  fifo_ff [2];
  logic       wp_ff, rp_ff;
  logic [1:0] cnt_ff;
  logic       ovr_pend_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rin_ff <= 1'b1;
      sck_ff <= 1'b0;
    end else begin
      rin_ff <= serial_in_pin_i;
      sck_ff <= serial_clock_pin_i;
    end
  end
  // sync mode samples on the rising clock edge, async at the vote point
  logic sync_edge, vote_pt, bit_end;
  assign sync_edge = serial_clock_pin_i & ~sck_ff;
  // count runs two behind the sample number, so count mid votes samples mid..mid+2
  assign vote_pt = sync_mode ? sync_edge : (tick & (rcnt_ff == mid));
  assign bit_end = sync_mode ? sync_edge : (tick & (rcnt_ff == ovs - 5'h01));
  logic bitval;
  assign bitval = sync_mode ? serial_in_pin_i : maj3({smp_ff[1:0], serial_in_pin_i});

  always_ff @(posedge clk_i) begin
    if (rst_i | ~rx_en) begin
      rx_st_ff <= RX_IDLE;
      rcnt_ff  <= '0;
      smp_ff   <= '1;
      rbit_ff  <= '0;
      rsh_ff   <= '0;
      rpar_ff  <= 1'b0;
      rpe_ff   <= 1'b0;
    end else begin
      if (tick) begin
        smp_ff <= {smp_ff[1:0], serial_in_pin_i};
      end
      unique case (rx_st_ff)
        RX_IDLE: begin
          if (rin_ff & ~serial_in_pin_i) begin
            rx_st_ff <= RX_START;  // falling edge, resync bit clock
            rcnt_ff  <= '0;
          end
        end
        RX_START: begin
          if (tick) begin
            rcnt_ff <= bit_end ? 5'h00 : rcnt_ff + 5'h01;
          end
          if (sync_mode | vote_pt) begin
            if (bitval) begin
              rx_st_ff <= RX_IDLE;  // false start
            end else if (~sync_mode) begin
              rx_st_ff <= RX_START;
            end
          end
          if (bit_end & ~bitval) begin
            rx_st_ff <= RX_DATA;
            rbit_ff  <= '0;
            rpar_ff  <= par_odd;
          end
        end
        RX_DATA, RX_PAR, RX_STOP: begin
          if (tick) begin
            rcnt_ff <= bit_end ? 5'h00 : rcnt_ff + 5'h01;
          end
          if (vote_pt) begin
            if (rx_st_ff == RX_DATA) begin
              rsh_ff  <= {bitval, rsh_ff[8:1]};  // lsb first
              rpar_ff <= rpar_ff ^ bitval;
              rbit_ff <= rbit_ff + 4'h1;
              if (rbit_ff + 4'h1 == nbits) begin
                rx_st_ff <= par_en ? RX_PAR : RX_STOP;
              end
            end else if (rx_st_ff == RX_PAR) begin
              rpe_ff   <= rpar_ff ^ bitval;
              rx_st_ff <= RX_STOP;
            end else begin
              rx_st_ff <= RX_IDLE;  // second stop ignored
            end
          end
        end
        default: rx_st_ff <= RX_IDLE;
      endcase
    end
  end

  // align a short character to bit 0
  logic [8:0] rdata_al;
  assign rdata_al = rsh_ff >> (4'h9 - nbits);
  assign rx_push = rx_en & (rx_st_ff == RX_STOP) & vote_pt;
  assign rx_new.par_err = par_en & rpe_ff;
  assign rx_new.frm_err = ~bitval;
  assign rx_new.ovr     = ovr_pend_ff;
  assign rx_new.ninth   = (nbits == 4'h9) ? rsh_ff[8] : 1'b0;
  assign rx_new.data    = (nbits == 4'h9) ? rsh_ff[7:0] : rdata_al[7:0];

  logic pop, full;
  assign full = (cnt_ff == 2'h2);
  assign pop  = rd_data & (cnt_ff != 2'h0);
  always_ff @(posedge clk_i) begin
    if (rst_i | ~rx_en) begin
      wp_ff       <= 1'b0;  // flush
      rp_ff       <= 1'b0;
      cnt_ff      <= '0;
      ovr_pend_ff <= 1'b0;
      fifo_ff[0]  <= '0;
      fifo_ff[1]  <= '0;
    end else begin
      if (rx_push & ~full) begin
        fifo_ff[wp_ff] <= rx_new;
        wp_ff          <= ~wp_ff;
      end
      if (pop) begin
        rp_ff <= ~rp_ff;
      end
      cnt_ff <= cnt_ff + {1'b0, rx_push & ~full} - {1'b0, pop};
      if (rx_push & full) begin
        ovr_pend_ff <= 1'b1;  // character lost
      end else if (rx_push | pop) begin
        ovr_pend_ff <= 1'b0;  // handed on with the next stored entry or cleared by read
      end
    end
  end
  rx_entry_t head;
  assign head = fifo_ff[rp_ff];
  logic rxc, ovr_flag;
  assign rxc      = rx_en & (cnt_ff != 2'h0);  // drops with the enable, not a cycle later
  assign ovr_flag = (rxc & head.ovr) | ovr_pend_ff;
  assign serial_in_pin_owned_o = rx_en;

  assign dre_irq_o = dre_ff & ctrl1_ff[C1_DRE_IE];
  assign txc_irq_o = txc_ff & ctrl1_ff[C1_TXC_IE];
  assign rxc_irq_o = rxc & ctrl1_ff[C1_RXC_IE];

  // read mux; status shows the head entry's flags
  logic [31:0] rmux;
  always_comb begin
    rmux = '0;
    unique case (adr_i)
      OFS_DATA: rmux[7:0] = rxc ? head.data : 8'h00;
      OFS_STATUS: begin
        rmux[ST_PAR_ERR] = rxc & head.par_err;
        rmux[ST_FRM_ERR] = rxc & head.frm_err;
        rmux[ST_OVERRUN] = ovr_flag;
        rmux[ST_TXC]     = txc_ff;
        rmux[ST_RXC]     = rxc;
        rmux[ST_DRE]     = dre_ff;
        rmux[ST_TXIRQ]   = txc_irq_o;
        rmux[ST_RXIRQ]   = rxc_irq_o;
        rmux[ST_DREIRQ]  = dre_irq_o;
      end
      OFS_CTRL1: rmux[11:0] = ctrl1_ff;
      OFS_CTRL2: rmux[3:0] = {ctrl2_ff[3:2], rxc & head.ninth, ctrl2_ff[C2_TX9]};
      OFS_BAUD: rmux[DIV_W-1:0] = baud_ff;
      default: rmux = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff  <= 1'b0;
      rdat_ff <= '0;
    end else begin
      ack_ff  <= req;
      rdat_ff <= rmux;
    end
  end
  assign ack_o = ack_ff;
  assign dat_o = rdat_ff;
endmodule

// File: tb/usart_tx_rx_core_asserts.sv
// port-level checker for the serial port core
`timescale 1ns/1ps
module usart_tx_rx_core_asserts
  import usart_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        serial_in_pin_i,
  input wire logic        serial_clock_pin_i,
  input wire logic        serial_out_pin_o,
  input wire logic        serial_out_pin_oe_o,
  input wire logic        serial_in_pin_owned_o,
  input wire logic        txc_irq_ack_i,
  input wire logic        dre_irq_o,
  input wire logic        txc_irq_o,
  input wire logic        rxc_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // shortest asynchronous bit is 8 clocks: double speed with divisor zero; a sync master bit can be 2
  sequence low_bit;
    !serial_out_pin_o [*8];
  endsequence
  sequence high_bit;
    serial_out_pin_o [*8];
  endsequence
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acked in one cycle");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held over two cycles");
  a_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i) && $past(stb_i))
    else $error("ack without request");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !ack_o && serial_out_pin_o && !serial_out_pin_oe_o
      && !dre_irq_o && !txc_irq_o && !rxc_irq_o)
    else $error("outputs not quiet after reset");
  a_drive_owned: assert property ($fell(serial_out_pin_o) |-> serial_out_pin_oe_o)
    else $error("line driven low while pin released");
  a_low_hold: assert property ($fell(serial_out_pin_o) |-> low_bit)
    else $error("low bit shorter than one bit time");
  a_high_hold: assert property ($rose(serial_out_pin_o) |-> high_bit)
    else $error("high bit shorter than one bit time");
  a_txc_stop: assert property ($rose(txc_irq_o) |-> serial_out_pin_o && $past(serial_out_pin_o, 7))
    else $error("transmit complete before stop bit ended");
  a_txc_service: assert property (txc_irq_ack_i |=> !txc_irq_o)
    else $error("transmit complete survives service");
  a_rxc_owned: assert property (rxc_irq_o |-> serial_in_pin_owned_o)
    else $error("receive request with receiver disabled");
endmodule

bind usart_tx_rx_core usart_tx_rx_core_asserts #(.DIV_W(DIV_W)) chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .serial_in_pin_i(serial_in_pin_i),
  .serial_clock_pin_i(serial_clock_pin_i), .serial_out_pin_o(serial_out_pin_o),
  .serial_out_pin_oe_o(serial_out_pin_oe_o), .serial_in_pin_owned_o(serial_in_pin_owned_o),
  .txc_irq_ack_i(txc_irq_ack_i), .dre_irq_o(dre_irq_o), .txc_irq_o(txc_irq_o), .rxc_irq_o(rxc_irq_o)
);

// File: tb/remote_uart.sv
// remote serial transceiver model facing the serial lines
`timescale 1ns/1ps
module remote_uart (
  input  wire logic clk_i,
  input  wire logic line_i,
  output logic      line_o,
  output logic      sck_o
);
  initial line_o = 1'b1; // idle high
  initial sck_o = 1'b0; // serial clock idles low
  // clocked frame: each bit stands across one rising clock edge
  task automatic clocked_send(input logic [8:0] d, input int nb);
    for (int i = 0; i <= nb + 1; i++) begin
      line_o <= (i == 0) ? 1'b0 : ((i > nb) ? 1'b1 : d[i-1]);
      repeat (2) @(posedge clk_i);
      sck_o <= 1'b1;
      repeat (2) @(posedge clk_i);
      sck_o <= 1'b0;
    end
  endtask
  task automatic put(input logic b, input int bl);
    line_o <= b;
    repeat (bl) @(posedge clk_i);
  endtask
  task automatic send(input logic [8:0] d, input int nb, input bit par, input bit odd, input bit bad_par,
                      input bit bad_stop, input int bl);
    logic [8:0] m;
    m = (9'h001 << nb) - 9'h001;
    put(1'b0, bl); // low start
    for (int i = 0; i < nb; i++) put(d[i], bl); // lsb first
    if (par) put(^(d & m) ^ odd ^ bad_par, bl);
    put(!bad_stop, bl); // stop high unless a frame fault is wanted
    put(1'b1, bl);
  endtask
  // samples at bit centres; a missing start falls out after the wait limit
  task automatic catch(output logic [8:0] d, output logic p, input int nb, input bit par, input int bl);
    int t;
    d = '0;
    p = 1'b0;
    t = 0;
    while (line_i !== 1'b0 && t < 4000) begin
      @(posedge clk_i);
      t++;
    end
    repeat (bl / 2) @(posedge clk_i);
    for (int i = 0; i < nb; i++) begin
      repeat (bl) @(posedge clk_i);
      d[i] = line_i;
    end
    if (par) begin
      repeat (bl) @(posedge clk_i);
      p = line_i;
    end
    repeat (bl) @(posedge clk_i);
  endtask
endmodule

// File: tb/usart_tx_rx_core_test.sv
// self-checking bench for the serial port core
`timescale 1ns/1ps
module usart_tx_rx_core_test;
  import usart_pkg::*;
  logic        clk_i   = 1'b0;
  logic        rst_i   = 1'b1;
  logic        cyc     = 1'b0;
  logic        stb     = 1'b0;
  logic        we      = 1'b0;
  logic        txc_ack = 1'b0;
  logic [7:0]  adr     = 8'h00;
  logic [3:0]  sel     = 4'h0;
  logic [31:0] dat     = 32'h0;
  logic [31:0] dat_o;
  logic [31:0] v;
  logic        ack_o;
  logic        rxd;
  logic        sck;
  logic        txd;
  logic        txd_oe;
  logic        rx_owned;
  logic        dre_irq;
  logic        txc_irq;
  logic        rxc_irq;
  logic [8:0]  d1;
  logic [8:0]  d2;
  logic        p1;
  logic        p2;
  int          n_errors    = 0;
  int          check_count = 0;
  int          cycles      = 0;
  usart_tx_rx_core uut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .serial_in_pin_i(rxd), .serial_clock_pin_i(sck),
    .serial_out_pin_o(txd), .serial_out_pin_oe_o(txd_oe), .serial_in_pin_owned_o(rx_owned),
    .txc_irq_ack_i(txc_ack), .dre_irq_o(dre_irq), .txc_irq_o(txc_irq), .rxc_irq_o(rxc_irq)
  );
  remote_uart peer (.clk_i(clk_i), .line_i(txd), .line_o(rxd), .sck_o(sck));
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one classic cycle; read data lands in v at the ack edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] wd);
    int t;
    t = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= wd;
    @(posedge clk_i);
    while (ack_o !== 1'b1 && t < 50) begin
      @(posedge clk_i);
      t++;
    end
    if (t >= 50) begin
      n_errors++;
      close_out();
    end
    v = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 4'hf, 32'h0);
  endtask
  // size and control one go in separate accesses: one lane per write
  task automatic cfg(input logic [2:0] sz, input logic [7:0] c1, input logic [7:0] c2);
    wb(1'b1, OFS_CTRL1, 4'h2, {21'h0, sz, 8'h00});
    wb(1'b1, OFS_CTRL1, 4'h1, {24'h0, c1});
    wb(1'b1, OFS_CTRL2, 4'h1, {24'h0, c2});
  endtask
  // status is read ahead of the data it belongs to
  task automatic rxchk(input logic [2:0] e, input logic [7:0] d);
    rd(OFS_STATUS);
    cmp("rx flags", {29'h0, e}, v & 32'h7);
    rd(OFS_DATA);
    cmp("rx data", {24'h0, d}, v & 32'hff);
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(OFS_STATUS);
    cmp("status reset", 32'h80, v);
    rd(OFS_CTRL1);
    cmp("ctrl1 reset", 32'h0, v);
    rd(OFS_BAUD);
    cmp("baud reset", {16'h0, BAUD_RESET}, v);
    wb(1'b1, 8'h20, 4'hf, 32'hffffffff);
    rd(8'h20);
    cmp("unmapped", 32'h0, v);
    cfg(3'h3, 8'h57, 8'h00);
    cmp("dre irq", 32'h1, {31'h0, dre_irq});
    fork
      begin
        wb(1'b1, OFS_DATA, 4'h1, 32'ha7);
        wb(1'b1, OFS_DATA, 4'h1, 32'h3c);
      end
      begin
        peer.catch(d1, p1, 8, 1'b1, 16);
        peer.catch(d2, p2, 8, 1'b1, 16);
      end
    join
    cmp("tx frame one", {22'h0, 1'b1, 9'h0a7}, {22'h0, p1, d1});
    cmp("tx frame two", {22'h0, 1'b0, 9'h03c}, {22'h0, p2, d2});
    repeat (12) @(posedge clk_i);
    rd(OFS_STATUS);
    cmp("tx flags", 32'ha0, v & 32'he0);
    wb(1'b1, OFS_STATUS, 4'h1, 32'h20);
    rd(OFS_STATUS);
    cmp("flag writes", 32'h20, v & 32'ha0);
    cmp("txc irq off", 32'h0, {31'h0, txc_irq});
    wb(1'b1, OFS_CTRL1, 4'h1, 32'h5f);
    cmp("txc irq on", 32'h1, {31'h0, txc_irq});
    txc_ack <= 1'b1;
    @(posedge clk_i);
    txc_ack <= 1'b0;
    @(posedge clk_i);
    cmp("txc serviced", 32'h0, {31'h0, txc_irq});
    cfg(SIZE_9BIT, 8'h03, 8'h01);
    fork
      wb(1'b1, OFS_DATA, 4'h1, 32'h5a);
      peer.catch(d1, p1, 9, 1'b0, 16);
    join
    cmp("tx ninth", 32'h15a, {23'h0, d1});
    peer.send(9'h1a5, 9, 1'b0, 1'b0, 1'b0, 1'b0, 16);
    rd(OFS_CTRL2);
    cmp("rx ninth", 32'h1, {31'h0, v[C2_RX9]});
    rd(OFS_DATA);
    cmp("rx low byte", 32'ha5, v & 32'hff);
    cfg(3'h3, 8'h67, 8'h00);
    peer.send(9'h03c, 8, 1'b1, 1'b1, 1'b0, 1'b0, 16);
    cmp("rxc irq", 32'h1, {31'h0, rxc_irq});
    peer.send(9'h081, 8, 1'b1, 1'b1, 1'b1, 1'b0, 16);
    rxchk(3'h0, 8'h3c);
    rxchk(3'h1, 8'h81);
    cmp("rxc irq clear", 32'h0, {31'h0, rxc_irq});
    peer.send(9'h055, 8, 1'b1, 1'b1, 1'b0, 1'b1, 16);
    rxchk(3'h2, 8'h55);
    peer.send(9'h011, 8, 1'b1, 1'b1, 1'b0, 1'b0, 16);
    peer.send(9'h022, 8, 1'b1, 1'b1, 1'b0, 1'b0, 16);
    peer.send(9'h033, 8, 1'b1, 1'b1, 1'b0, 1'b0, 16);
    rd(OFS_STATUS);
    cmp("overrun", 32'h4, v & 32'h4);
    rd(OFS_DATA);
    cmp("kept one", 32'h11, v & 32'hff);
    rd(OFS_STATUS);
    rd(OFS_DATA);
    cmp("kept two", 32'h22, v & 32'hff);
    rd(OFS_STATUS);
    cmp("third lost", 32'h0, v & 32'h44);
    cfg(3'h3, 8'h03, 8'h08);
    peer.send(9'h096, 8, 1'b0, 1'b0, 1'b0, 1'b0, 8);
    rxchk(3'h0, 8'h96);
    wb(1'b1, OFS_CTRL1, 4'h2, 32'h0b00);
    peer.clocked_send(9'h0c3, 8);
    rxchk(3'h0, 8'hc3);
    wb(1'b1, OFS_CTRL1, 4'h2, 32'h0300);
    peer.send(9'h042, 8, 1'b0, 1'b0, 1'b0, 1'b0, 8);
    wb(1'b1, OFS_CTRL1, 4'h1, 32'h02);
    rd(OFS_STATUS);
    cmp("rx flushed", 32'h0, v & 32'h40);
    cmp("rx pin freed", 32'h0, {31'h0, rx_owned});
    fork
      begin
        wb(1'b1, OFS_DATA, 4'h1, 32'h69);
        wb(1'b1, OFS_CTRL1, 4'h1, 32'h00);
      end
      peer.catch(d1, p1, 8, 1'b0, 8);
    join
    cmp("tx finishes", 32'h69, {23'h0, d1});
    repeat (10) @(posedge clk_i);
    cmp("tx pin freed", 32'h0, {31'h0, txd_oe});
    close_out();
  end
endmodule
